/* dv/interrupt_priority_regs_5_to_9_tb.sv */
// self-checking bench for the priority control registers 5 to 9
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_regs_5_to_9_tb;
  import iprc_pkg::*;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [15:0] e;
  } iprc_row_t;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic mclk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] prio [20];
  logic [19:0] sourceEnable;
  logic [15:0] shadow [IPRC_NUM_REGS];
  logic err;
  int badCount, nCompared;
  // rows: address, write data, strobes, expected register value
  iprc_row_t rows [8] = '{
    '{12'h000, 32'hffffffff, 4'hf, 16'h7777},
    '{12'h000, 32'h00000100, 4'h2, 16'h0177},
    '{12'h004, 32'h00000123, 4'hf, 16'h0123},
    '{12'h008, 32'h00005670, 4'hf, 16'h5670},
    '{12'h00c, 32'h000089ab, 4'hf, 16'h0123},
    '{12'h010, 32'h00004567, 4'h1, 16'h4467},
    '{12'h000, 32'h00000000, 4'h2, 16'h0077},
    '{12'h010, 32'h00007100, 4'h2, 16'h7167}};
  // ---------------------------------------------------------------
  // device under test
  // ---------------------------------------------------------------
  iprc_regs i_dut (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture8_prio(prio[0]), .capture7_prio(prio[1]),
    .adc2_done_prio(prio[2]), .ext_irq1_prio(prio[3]),
    .timer4_prio(prio[4]), .compare4_prio(prio[5]),
    .compare3_prio(prio[6]), .dma_ch2_done_prio(prio[7]),
    .uart2_tx_prio(prio[8]), .uart2_rx_prio(prio[9]),
    .ext_irq2_prio(prio[10]), .timer5_prio(prio[11]),
    .can1_event_prio(prio[12]), .can1_rx_prio(prio[13]),
    .spi2_event_prio(prio[14]), .spi2_error_prio(prio[15]),
    .capture5_prio(prio[16]), .capture4_prio(prio[17]),
    .capture3_prio(prio[18]), .dma_ch3_done_prio(prio[19]),
    .sourceEnable(sourceEnable));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one apb transfer, starts and ends right after a rising edge
  task automatic apbXfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
  endtask
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      $display("BAD %0t value %h expected %h", $time, got, exp);
      badCount++;
    end
  endtask
  task automatic chkFlag(input logic got, input logic exp);
    nCompared++;
    if (got !== exp) begin
      $display("BAD %0t flag %b expected %b", $time, got, exp);
      badCount++;
    end
  endtask
  // register k as seen on the priority outputs
  function automatic logic [15:0] view(input int k);
    return {1'b0, prio[4*k], 1'b0, prio[4*k+1],
            1'b0, prio[4*k+2], 1'b0, prio[4*k+3]};
  endfunction
  // a source is enabled unless its field is zero
  function automatic logic [19:0] seExp();
    logic [19:0] se;
    for (int i = 0; i < 20; i++) begin
      se[i] = |shadow[i/4][12-4*(i%4) +: 3];
    end
    return se;
  endfunction
  task automatic stopTest();
    $display("compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // whole sequence takes about 60 cycles
  initial begin
    repeat (2000) @(posedge mclk);
    badCount++;
    stopTest();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= '0;
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    // reset values, outputs and readback
    for (int k = 0; k < IPRC_NUM_REGS; k++) begin
      shadow[k] = IPRC_RESET_VAL;
      apbXfer(1'b0, 12'(4*k), 32'h0, 4'h0);
      chkVal(rd, 32'h00004444);
      chkVal(view(k), 16'h4444);
    end
    chkVal(sourceEnable, 20'hfffff);
    // table rows, back to back write then read
    foreach (rows[i]) begin
      shadow[rows[i].a[4:2]] = rows[i].e;
      apbXfer(1'b1, rows[i].a, rows[i].d, rows[i].s);
      chkFlag(err, 1'b0);
      apbXfer(1'b0, rows[i].a, 32'h0, 4'h0);
      chkVal(rd, {16'h0, rows[i].e});
      chkVal(view(rows[i].a[4:2]), rows[i].e);
      chkVal(sourceEnable, seExp());
    end
    // unmapped and misaligned accesses are refused
    apbXfer(1'b1, 12'h014, 32'h0, 4'hf);
    chkFlag(err, 1'b1);
    apbXfer(1'b1, 12'h002, 32'h0, 4'hf);
    chkFlag(err, 1'b1);
    apbXfer(1'b0, 12'h000, 32'h0, 4'h0);
    chkVal(rd, 32'h00000077);
    apbXfer(1'b0, 12'h014, 32'h0, 4'h0);
    chkVal(rd, 32'h0);
    chkFlag(err, 1'b1);
    // second reset in mid-run
    psel <= 1'b0;
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    apbXfer(1'b0, 12'h010, 32'h0, 4'h0);
    chkVal(rd, 32'h00004444);
    chkVal(sourceEnable, 20'hfffff);
    psel <= 1'b0;
    @(posedge mclk);
    stopTest();
  end
endmodule
`default_nettype wire

/* hw/iprc_regs.sv */
// apb slave holding interrupt priority control registers 5 to 9
// Operation
// - field value 111 gives its source priority 7, the highest.
// - values 001 to 111 map linearly to levels 1 to 7.
// - field value 000 disables its source completely.
// - bits 15, 11, 7, 3 read zero and ignore writes.
// - every field resets to 100, priority 4; all fields read/write.
// - reg 5: capture8, capture7, adc2 done, external irq 1.
// - reg 6: timer4, compare4, compare3, dma channel 2 done.
// - reg 7: uart2 tx, uart2 rx, external irq 2, timer5.
// - reg 8: can1 event, can1 rx, spi2 event, spi2 error.
// - reg 9: capture5, capture4, capture3, dma channel 3 done.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module iprc_regs
  import iprc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // priority levels to arbitration, 0 means source disabled
  output logic [2:0] capture8_prio,
  output logic [2:0] capture7_prio,
  output logic [2:0] adc2_done_prio,
  output logic [2:0] ext_irq1_prio,
  output logic [2:0] timer4_prio,
  output logic [2:0] compare4_prio,
  output logic [2:0] compare3_prio,
  output logic [2:0] dma_ch2_done_prio,
  output logic [2:0] uart2_tx_prio,
  output logic [2:0] uart2_rx_prio,
  output logic [2:0] ext_irq2_prio,
  output logic [2:0] timer5_prio,
  output logic [2:0] can1_event_prio,
  output logic [2:0] can1_rx_prio,
  output logic [2:0] spi2_event_prio,
  output logic [2:0] spi2_error_prio,
  output logic [2:0] capture5_prio,
  output logic [2:0] capture4_prio,
  output logic [2:0] capture3_prio,
  output logic [2:0] dma_ch3_done_prio,
  // per source enable, low when field is 000
  output logic [19:0] sourceEnable
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ADDR_W < 12) begin : g_chk
    $error("iprc_regs: ADDR_W must be at least 12");
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [15:0] priorityCtrl5;
  logic [15:0] priorityCtrl6;
  logic [15:0] priorityCtrl7;
  logic [15:0] priorityCtrl8;
  logic [15:0] priorityCtrl9;
  logic [15:0] next_priorityCtrl5;
  logic [15:0] next_priorityCtrl6;
  logic [15:0] next_priorityCtrl7;
  logic [15:0] next_priorityCtrl8;
  logic [15:0] next_priorityCtrl9;
  logic [31:0] next_prdata;
  logic [15:0] lowMask;
  logic [15:0] wrData;
  logic [11:0] offset;
  logic access;
  logic hit;

  // access phase decode; zero wait state slave
  assign access = psel & penable;
  assign offset = paddr[11:0];
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  // byte lanes of the low half-word only
  assign lowMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // address hit: mapped word and aligned
  always_comb begin
    case (offset)
      IPRC_OFS_CTRL5: hit = 1'b1;
      IPRC_OFS_CTRL6: hit = 1'b1;
      IPRC_OFS_CTRL7: hit = 1'b1;
      IPRC_OFS_CTRL8: hit = 1'b1;
      IPRC_OFS_CTRL9: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // write path
  // ---------------------------------------------------------------
  // merge written lanes, unimplemented bits stay zero
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [15:0] lm);
    merge = ((wd & lm) | (old & ~lm)) & IPRC_IMPL_MASK;
  endfunction

  assign wrData = pwdata[15:0];

  // next register values
  always_comb begin
    next_priorityCtrl5 = priorityCtrl5;
    next_priorityCtrl6 = priorityCtrl6;
    next_priorityCtrl7 = priorityCtrl7;
    next_priorityCtrl8 = priorityCtrl8;
    next_priorityCtrl9 = priorityCtrl9;
    if (reset) begin
      next_priorityCtrl5 = IPRC_RESET_VAL;
      next_priorityCtrl6 = IPRC_RESET_VAL;
      next_priorityCtrl7 = IPRC_RESET_VAL;
      next_priorityCtrl8 = IPRC_RESET_VAL;
      next_priorityCtrl9 = IPRC_RESET_VAL;
    end else if (access && pwrite) begin
      case (offset)
        IPRC_OFS_CTRL5: begin
          next_priorityCtrl5 = merge(priorityCtrl5, wrData, lowMask);
        end
        IPRC_OFS_CTRL6: begin
          next_priorityCtrl6 = merge(priorityCtrl6, wrData, lowMask);
        end
        IPRC_OFS_CTRL7: begin
          next_priorityCtrl7 = merge(priorityCtrl7, wrData, lowMask);
        end
        IPRC_OFS_CTRL8: begin
          next_priorityCtrl8 = merge(priorityCtrl8, wrData, lowMask);
        end
        IPRC_OFS_CTRL9: begin
          next_priorityCtrl9 = merge(priorityCtrl9, wrData, lowMask);
        end
        default: begin
        end
      endcase
    end
  end

  // register the priority words
  always_ff @(posedge mclk) begin
    priorityCtrl5 <= next_priorityCtrl5;
    priorityCtrl6 <= next_priorityCtrl6;
    priorityCtrl7 <= next_priorityCtrl7;
    priorityCtrl8 <= next_priorityCtrl8;
    priorityCtrl9 <= next_priorityCtrl9;
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read data, registered; prdata valid during access phase
  always_comb begin
    next_prdata = prdata;
    if (reset) begin
      next_prdata = 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (offset)
        IPRC_OFS_CTRL5: next_prdata = {16'h0000, priorityCtrl5};
        IPRC_OFS_CTRL6: next_prdata = {16'h0000, priorityCtrl6};
        IPRC_OFS_CTRL7: next_prdata = {16'h0000, priorityCtrl7};
        IPRC_OFS_CTRL8: next_prdata = {16'h0000, priorityCtrl8};
        IPRC_OFS_CTRL9: next_prdata = {16'h0000, priorityCtrl9};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // register read data
  always_ff @(posedge mclk) begin
    prdata <= next_prdata;
  end

  // ---------------------------------------------------------------
  // field outputs to arbitration
  // ---------------------------------------------------------------
  // register 5 fields
  assign capture8_prio = priorityCtrl5[IPRC_FLD_HI +: IPRC_FLD_W];
  assign capture7_prio = priorityCtrl5[IPRC_FLD_MH +: IPRC_FLD_W];
  assign adc2_done_prio = priorityCtrl5[IPRC_FLD_ML +: IPRC_FLD_W];
  assign ext_irq1_prio = priorityCtrl5[IPRC_FLD_LO +: IPRC_FLD_W];
  // register 6 fields
  assign timer4_prio = priorityCtrl6[IPRC_FLD_HI +: IPRC_FLD_W];
  assign compare4_prio = priorityCtrl6[IPRC_FLD_MH +: IPRC_FLD_W];
  assign compare3_prio = priorityCtrl6[IPRC_FLD_ML +: IPRC_FLD_W];
  assign dma_ch2_done_prio = priorityCtrl6[IPRC_FLD_LO +: IPRC_FLD_W];
  // register 7 fields
  assign uart2_tx_prio = priorityCtrl7[IPRC_FLD_HI +: IPRC_FLD_W];
  assign uart2_rx_prio = priorityCtrl7[IPRC_FLD_MH +: IPRC_FLD_W];
  assign ext_irq2_prio = priorityCtrl7[IPRC_FLD_ML +: IPRC_FLD_W];
  assign timer5_prio = priorityCtrl7[IPRC_FLD_LO +: IPRC_FLD_W];
  // register 8 fields
  assign can1_event_prio = priorityCtrl8[IPRC_FLD_HI +: IPRC_FLD_W];
  assign can1_rx_prio = priorityCtrl8[IPRC_FLD_MH +: IPRC_FLD_W];
  assign spi2_event_prio = priorityCtrl8[IPRC_FLD_ML +: IPRC_FLD_W];
  assign spi2_error_prio = priorityCtrl8[IPRC_FLD_LO +: IPRC_FLD_W];
  // register 9 fields
  assign capture5_prio = priorityCtrl9[IPRC_FLD_HI +: IPRC_FLD_W];
  assign capture4_prio = priorityCtrl9[IPRC_FLD_MH +: IPRC_FLD_W];
  assign capture3_prio = priorityCtrl9[IPRC_FLD_ML +: IPRC_FLD_W];
  assign dma_ch3_done_prio = priorityCtrl9[IPRC_FLD_LO +: IPRC_FLD_W];

  // level is the field value itself, 1..7 linear, 7 on top
  // a zero field masks the source from arbitration
  always_comb begin
    sourceEnable[0] = capture8_prio != IPRC_PRIO_OFF;
    sourceEnable[1] = capture7_prio != IPRC_PRIO_OFF;
    sourceEnable[2] = adc2_done_prio != IPRC_PRIO_OFF;
    sourceEnable[3] = ext_irq1_prio != IPRC_PRIO_OFF;
    sourceEnable[4] = timer4_prio != IPRC_PRIO_OFF;
    sourceEnable[5] = compare4_prio != IPRC_PRIO_OFF;
    sourceEnable[6] = compare3_prio != IPRC_PRIO_OFF;
    sourceEnable[7] = dma_ch2_done_prio != IPRC_PRIO_OFF;
    sourceEnable[8] = uart2_tx_prio != IPRC_PRIO_OFF;
    sourceEnable[9] = uart2_rx_prio != IPRC_PRIO_OFF;
    sourceEnable[10] = ext_irq2_prio != IPRC_PRIO_OFF;
    sourceEnable[11] = timer5_prio != IPRC_PRIO_OFF;
    sourceEnable[12] = can1_event_prio != IPRC_PRIO_OFF;
    sourceEnable[13] = can1_rx_prio != IPRC_PRIO_OFF;
    sourceEnable[14] = spi2_event_prio != IPRC_PRIO_OFF;
    sourceEnable[15] = spi2_error_prio != IPRC_PRIO_OFF;
    sourceEnable[16] = capture5_prio != IPRC_PRIO_OFF;
    sourceEnable[17] = capture4_prio != IPRC_PRIO_OFF;
    sourceEnable[18] = capture3_prio != IPRC_PRIO_OFF;
    sourceEnable[19] = dma_ch3_done_prio != IPRC_PRIO_OFF;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // unimplemented bits never hold a one in any register
  a_unimpl_zero: assert property (
    @(posedge mclk) disable iff (reset)
    (priorityCtrl5 & ~IPRC_IMPL_MASK) == 16'h0000 &&
    (priorityCtrl6 & ~IPRC_IMPL_MASK) == 16'h0000 &&
    (priorityCtrl7 & ~IPRC_IMPL_MASK) == 16'h0000 &&
    (priorityCtrl8 & ~IPRC_IMPL_MASK) == 16'h0000 &&
    (priorityCtrl9 & ~IPRC_IMPL_MASK) == 16'h0000)
    else $error("unimplemented bits set");
  // read data shows zero outside the fields
  a_read_high: assert property (
    @(posedge mclk) disable iff (reset)
    access && !pwrite |->
    (prdata & ~{16'h0000, IPRC_IMPL_MASK}) == 32'h0000_0000)
    else $error("unimplemented read bits not zero");
  // every word back at level 4 one edge after reset
  a_reset_value: assert property (
    @(posedge mclk)
    $past(reset) |-> priorityCtrl5 == IPRC_RESET_VAL &&
    priorityCtrl6 == IPRC_RESET_VAL && priorityCtrl7 == IPRC_RESET_VAL &&
    priorityCtrl8 == IPRC_RESET_VAL && priorityCtrl9 == IPRC_RESET_VAL &&
    ext_irq1_prio == 3'h4 && prdata == 32'h0000_0000)
    else $error("priority not 4 after reset");
  // register 5 field positions
  a_map_reg5: assert property (
    @(posedge mclk) disable iff (reset)
    access && pwrite && offset == IPRC_OFS_CTRL5 && pstrb[1] && pstrb[0]
    |=> capture8_prio == $past(pwdata[14:12]) &&
    adc2_done_prio == $past(pwdata[6:4]))
    else $error("register 5 fields misplaced");
  // register 6 top field takes the written value
  a_write_lands: assert property (
    @(posedge mclk) disable iff (reset)
    access && pwrite && offset == IPRC_OFS_CTRL6 && pstrb[1]
    |=> timer4_prio == $past(pwdata[14:12]))
    else $error("timer4 priority write lost");
  // 111 gives the top level and an enabled source
  a_top_level: assert property (
    @(posedge mclk) disable iff (reset)
    access && pwrite && offset == IPRC_OFS_CTRL5 && pstrb[0] &&
    pwdata[2:0] == IPRC_PRIO_TOP
    |=> ext_irq1_prio == 3'h7 && sourceEnable[3])
    else $error("111 does not give level 7");
  // writing 000 masks the source
  a_disable_src: assert property (
    @(posedge mclk) disable iff (reset)
    access && pwrite && offset == IPRC_OFS_CTRL8 && pstrb[1] &&
    pwdata[14:12] == IPRC_PRIO_OFF
    |=> can1_event_prio == 3'h0 && !sourceEnable[12])
    else $error("zero field not disabling source");
  // register 8 low field positions
  a_field_map8: assert property (
    @(posedge mclk) disable iff (reset)
    access && pwrite && offset == IPRC_OFS_CTRL8 && pstrb[0]
    |=> spi2_error_prio == $past(pwdata[2:0]) &&
    spi2_event_prio == $past(pwdata[6:4]))
    else $error("register 8 low fields misplaced");
  // a write elsewhere leaves register 7 alone
  a_other_hold: assert property (
    @(posedge mclk) disable iff (reset)
    access && pwrite && offset != IPRC_OFS_CTRL7
    |=> $stable(priorityCtrl7))
    else $error("register 7 changed by foreign write");
  // read data of register 9 stands in the access phase
  a_read_back: assert property (
    @(posedge mclk) disable iff (reset)
    psel && !penable && !pwrite && offset == IPRC_OFS_CTRL9
    ##1 access |-> prdata == {16'h0000, priorityCtrl9})
    else $error("register 9 read mismatch");
  // 001 gives the lowest enabled level
  a_linear_lvl: assert property (
    @(posedge mclk) disable iff (reset)
    access && pwrite && offset == IPRC_OFS_CTRL5 && pstrb[1] &&
    pwdata[10:8] == 3'h1
    |=> capture7_prio == 3'h1 && sourceEnable[1])
    else $error("001 does not give level 1");

endmodule
`default_nettype wire

/* inc/iprc_pkg.sv */
// package: offsets, field layout and reset values of priority registers 5-9
package iprc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [11:0] IPRC_OFS_CTRL5 = 12'h000;
  localparam logic [11:0] IPRC_OFS_CTRL6 = 12'h004;
  localparam logic [11:0] IPRC_OFS_CTRL7 = 12'h008;
  localparam logic [11:0] IPRC_OFS_CTRL8 = 12'h00c;
  localparam logic [11:0] IPRC_OFS_CTRL9 = 12'h010;
  localparam int IPRC_NUM_REGS = 5;
  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int IPRC_FLD_W = 3;
  localparam int IPRC_FLD_HI = 12;
  localparam int IPRC_FLD_MH = 8;
  localparam int IPRC_FLD_ML = 4;
  localparam int IPRC_FLD_LO = 0;
  // implemented bits: 14-12, 10-8, 6-4, 2-0
  localparam logic [15:0] IPRC_IMPL_MASK = 16'h7777;
  // each field resets to 100, priority level 4
  localparam logic [15:0] IPRC_RESET_VAL = 16'h4444;
  localparam logic [2:0] IPRC_PRIO_OFF = 3'h0;
  localparam logic [2:0] IPRC_PRIO_TOP = 3'h7;
endpackage
